// ### rtl/sar_adc_sequencer.sv
// sequencer, result store and register file of a 10-bit sar converter
// assumes classic wishbone master on i_mclk; analog side on pins
// Operation
// - sixteen read-only 10-bit result entries
// - sample bit starts; done after batch
// - sequential mode: one sample clock per channel
// - simultaneous mode: sample together, convert serially
// - channel count selects 1, 2, 4
// - samples per interrupt 1 to 16
// - split store alternates halves per batch
// - samples per interrupt at bits 5:2
// - alternate bit swaps input sets per sequence
// - scan steps channel 0 through mask
// - code 000: clearing sample bit converts
// - code 111: convert after programmed clocks
// - external triggers add a sync clock
// - auto with one clock gives 13
// - turning off aborts, no partial write
// - turn-off beats simultaneous auto start
// - after abort resume at next channel; simultaneous mode restarts at channel 0
// - twelve converter clocks, divider sets period
// - clock source bit picks rc oscillator
`timescale 1ns/100ps
`default_nettype none
module sar_adc_sequencer
  import sar_adc_pkg::*;
(
  input  wire logic        i_mclk,
  input  wire logic        i_rst,
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [7:0]  i_wb_adr,
  input  wire logic [31:0] i_wb_dat,
  input  wire logic [3:0]  i_wb_sel,
  output logic      [31:0] o_wb_dat,
  output logic             o_wb_ack,
  input  wire logic        i_rc_clk,
  input  wire logic [2:0]  i_ext_trig,
  input  wire logic [9:0]  i_conv_result,
  output logic             o_module_on,
  output logic      [3:0]  o_sh_acquire,
  output logic             o_conv_active,
  output logic      [1:0]  o_conv_ch,
  output logic      [3:0]  o_ch0_input,
  output logic      [1:0]  o_ch123_group,
  output logic             o_use_set_b,
  output logic      [15:0] o_pin_digital,
  output logic             o_conv_irq_flag,
  output logic             o_done
);
  import sar_adc_pkg::*;

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw,
                                        input logic [1:0] sel);
    merge = {sel[1] ? nw[15:8] : old[15:8], sel[0] ? nw[7:0] : old[7:0]};
  endfunction

  function automatic logic [3:0] chan_mask(input logic [1:0] chps);
    chan_mask = (chps == 2'h0) ? 4'h1 : (chps == 2'h1) ? 4'h3 : 4'hf;
  endfunction

  function automatic logic [1:0] last_chan(input logic [1:0] chps);
    last_chan = (chps == 2'h0) ? 2'h0 : (chps == 2'h1) ? 2'h1 : 2'h3;
  endfunction

  // lowest flagged input at or above 'from'; msb says one was found
  function automatic logic [4:0] next_scan(input logic [15:0] mask, input logic [3:0] from);
    next_scan = 5'h00;
    for (int i = RES_DEPTH - 1; i >= 0; i--) begin
      if (mask[i] && (4'(i) >= from)) begin
        next_scan = {1'b1, 4'(i)};
      end
    end
  endfunction

  function automatic logic [15:0] fmt(input logic [9:0] r, input logic [1:0] form);
    unique case (form)
      FORM_INT:  fmt = {6'h00, r};
      FORM_SINT: fmt = {{7{~r[9]}}, r[8:0]};
      FORM_FRAC: fmt = {r, 6'h00};
      default:   fmt = {~r[9], r[8:0], 6'h00};
    endcase
  endfunction

  logic [15:0]      cr1_q;
  logic [15:0]      cr2_q;
  logic [15:0]      cr3_q;
  logic [15:0]      chs_q;
  logic [15:0]      pcfg_q;
  logic [15:0]      scan_q;
  logic             sample_active_q;
  logic             done_q;
  logic             flag_q;
  logic             ack_q;
  logic [31:0]      dat_q;
  logic [RES_W-1:0] mem [RES_DEPTH];
  seq_state_t       state_q;
  logic [1:0]       ch_q;
  logic [4:0]       sam_cnt_q;
  logic [3:0]       conv_cnt_q;
  logic [3:0]       seq_cnt_q;
  logic [3:0]       wr_ptr_q;
  logic [3:0]       scan_pos_q;
  logic             half_q;
  logic             alt_b_q;
  logic [2:0]       trig_s1_q;
  logic [2:0]       trig_s2_q;
  logic [2:0]       trig_s3_q;
  logic [9:0]       res_s1_q;
  logic [9:0]       res_s2_q;
  logic             tad;

  // bus decode
  logic        req;
  logic        wr_go;
  logic [5:0]  idx;
  logic [15:0] cr1_new;
  logic [15:0] rd_val;
  assign req     = i_wb_cyc & i_wb_stb;
  assign wr_go   = req & i_wb_we & ack_q;
  assign idx     = i_wb_adr[7:2];
  assign cr1_new = merge(cr1_q, i_wb_dat[15:0], i_wb_sel[1:0]);

  // configuration fields
  logic        on;
  logic        stop;
  logic [2:0]  ssrc;
  logic        simul;
  logic        multi;
  logic        split;
  logic [3:0]  smpi;
  logic [1:0]  chps;
  logic [4:0]  auto_sample_clocks;
  assign on    = cr1_q[CR1_ON];
  // a write to module_on counts in its own cycle, so on plus sample in one write starts
  assign stop  = (wr_go && idx == IDX_CR1) ? !cr1_new[CR1_ON] : ~on;
  assign ssrc  = cr1_q[CR1_SSRC +: 3];
  assign chps  = cr2_q[CR2_CHPS +: 2];
  assign multi = (chps != 2'h0);
  assign simul = cr1_q[CR1_SIMULTANEOUS_SAMPLE_EN] & multi;
  assign split = cr2_q[CR2_BUFFER_SPLIT_EN];
  assign smpi  = cr2_q[CR2_SMPI +: 4];
  assign auto_sample_clocks  = (cr3_q[CR3_AUTO_SAMPLE_CLOCKS +: 5] == 5'h00) ? AUTO_SAMPLE_CLOCKS_MIN : cr3_q[CR3_AUTO_SAMPLE_CLOCKS +: 5];

  // sequence events
  logic       conv_end;
  logic       last_ch;
  logic       seq_end;
  logic       irq_evt;
  logic       mem_we;
  logic       ext_edge;
  logic       auto_go;
  logic       sw_go;
  logic [4:0] scan_hit;
  logic [3:0] wr_addr;
  assign last_ch  = (ch_q == last_chan(chps));
  assign conv_end = (state_q == ST_CONV) && tad && (conv_cnt_q == CONV_LAST);
  assign seq_end  = conv_end & last_ch;
  assign irq_evt  = seq_end & (seq_cnt_q == smpi) & ~stop;
  assign mem_we   = conv_end & ~stop;
  assign ext_edge = (ssrc >= SSRC_EXT1) && (ssrc <= SSRC_EXT3)
                    && trig_s2_q[ssrc[1:0] - 2'h1] && !trig_s3_q[ssrc[1:0] - 2'h1];
  assign auto_go  = (ssrc == SSRC_AUTO) && tad && ({1'b0, sam_cnt_q} + 6'h01 >= {1'b0, auto_sample_clocks});
  assign sw_go    = (ssrc == SSRC_SW) && !sample_active_q;
  assign scan_hit = next_scan(scan_q, scan_pos_q);
  assign wr_addr  = split ? {half_q, wr_ptr_q[2:0]} : wr_ptr_q;

  conv_clock_gen #(
    .DIV_W (6)
  ) u_clk (
    .i_mclk   (i_mclk),
    .i_rst    (i_rst),
    .i_run    (on),
    .i_div    (cr3_q[CR3_ADCS +: 6]),
    .i_rc_sel (cr3_q[CR3_RC_CLOCK_SELECT]),
    .i_rc_clk (i_rc_clk),
    .o_tad    (tad)
  );

  // pins from the analog side
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      trig_s1_q <= 3'h0;
      trig_s2_q <= 3'h0;
      trig_s3_q <= 3'h0;
      res_s1_q  <= 10'h000;
      res_s2_q  <= 10'h000;
    end else begin
      trig_s1_q <= i_ext_trig;
      trig_s2_q <= trig_s1_q;
      trig_s3_q <= trig_s2_q;
      res_s1_q  <= i_conv_result;
      res_s2_q  <= res_s1_q;
    end
  end

  // bus slave: ack one cycle after request, write lands on the ack edge
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= req & ~ack_q;
      if (req && !ack_q) begin
        dat_q <= {16'h0000, rd_val};
      end
    end
  end

  always_comb begin
    rd_val = RST16;
    if (idx[5:4] == IDX_RES_HI) begin
      rd_val = fmt(mem[idx[3:0]], cr1_q[CR1_FORM +: 2]);
    end else begin
      unique case (idx)
        IDX_CR1:  rd_val = cr1_q | {11'h000, flag_q, 2'h0, sample_active_q, done_q};
        IDX_CR2:  rd_val = cr2_q | (16'h0001 << CR2_HALF);
        IDX_CR3:  rd_val = cr3_q;
        IDX_CHS:  rd_val = chs_q;
        IDX_PCFG: rd_val = pcfg_q;
        IDX_SCAN: rd_val = scan_q;
        default:  rd_val = RST16;
      endcase
      if (idx == IDX_CR2 && !half_q) begin
        rd_val[CR2_HALF] = 1'b0;
      end
    end
  end

  // configuration registers; result entries ignore writes
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      cr1_q  <= RST16;
      cr2_q  <= RST16;
      cr3_q  <= RST16;
      chs_q  <= RST16;
      pcfg_q <= RST16;
      scan_q <= RST16;
    end else if (wr_go) begin
      unique case (idx)
        IDX_CR1:  cr1_q  <= cr1_new & CR1_RW;
        IDX_CR2:  cr2_q  <= merge(cr2_q, i_wb_dat[15:0], i_wb_sel[1:0]) & CR2_RW;
        IDX_CR3:  cr3_q  <= merge(cr3_q, i_wb_dat[15:0], i_wb_sel[1:0]) & CR3_RW;
        IDX_CHS:  chs_q  <= merge(chs_q, i_wb_dat[15:0], i_wb_sel[1:0]);
        IDX_PCFG: pcfg_q <= merge(pcfg_q, i_wb_dat[15:0], i_wb_sel[1:0]);
        IDX_SCAN: scan_q <= merge(scan_q, i_wb_dat[15:0], i_wb_sel[1:0]);
        default:  ;
      endcase
    end
  end

  // sample bit: hardware re-arm wins over a software write
  always_ff @(posedge i_mclk) begin
    if (i_rst || stop) begin
      sample_active_q <= 1'b0;
    end else if (conv_end && (last_ch || !simul) && cr1_q[CR1_AUTO_SAMPLE_EN]) begin
      sample_active_q <= 1'b1;
    end else if (wr_go && idx == IDX_CR1) begin
      sample_active_q <= cr1_new[CR1_SAMPLE_ACTIVE];
    end else if (state_q == ST_SAMPLE && (auto_go || ext_edge)) begin
      sample_active_q <= 1'b0;
    end
  end

  // done and flag: set wins over a software clear
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      done_q <= 1'b0;
      flag_q <= 1'b0;
    end else if (irq_evt) begin
      done_q <= 1'b1;
      flag_q <= 1'b1;
    end else if (wr_go && idx == IDX_CR1) begin
      done_q <= done_q & cr1_new[CR1_DONE];
      flag_q <= flag_q & cr1_new[CR1_FLAG];
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      state_q    <= ST_IDLE;
      sam_cnt_q  <= 5'h00;
      conv_cnt_q <= 4'h0;
    end else if (stop) begin
      state_q    <= ST_IDLE;
      sam_cnt_q  <= 5'h00;
      conv_cnt_q <= 4'h0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          sam_cnt_q <= 5'h00;
          if (sample_active_q) begin
            state_q <= ST_SAMPLE;
          end
        end
        ST_SAMPLE: begin
          if (tad && sam_cnt_q != 5'h1f) begin
            sam_cnt_q <= sam_cnt_q + 5'h01;
          end
          if (auto_go || sw_go) begin
            state_q    <= ST_CONV;
            conv_cnt_q <= 4'h0;
          end else if (ext_edge) begin
            state_q <= ST_SYNC;
          end
        end
        ST_SYNC: begin
          if (tad) begin
            state_q    <= ST_CONV;
            conv_cnt_q <= 4'h0;
          end
        end
        ST_CONV: begin
          if (tad) begin
            conv_cnt_q <= (conv_cnt_q == CONV_LAST) ? 4'h0 : conv_cnt_q + 4'h1;
          end
          if (conv_end && !(simul && !last_ch)) begin
            state_q   <= cr1_q[CR1_AUTO_SAMPLE_EN] ? ST_SAMPLE : ST_IDLE;
            sam_cnt_q <= 5'h00;
          end
        end
      endcase
    end
  end

  // channel index steps past an aborted channel so sequencing resumes at the next one; simultaneous mode restarts at 0
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      ch_q <= 2'h0;
    end else if (stop && state_q == ST_CONV) begin
      ch_q <= (simul || last_ch) ? 2'h0 : ch_q + 2'h1;
    end else if (conv_end && !stop) begin
      ch_q <= last_ch ? 2'h0 : ch_q + 2'h1;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      seq_cnt_q  <= 4'h0;
      wr_ptr_q   <= 4'h0;
      half_q     <= 1'b0;
      alt_b_q    <= 1'b0;
      scan_pos_q <= 4'h0;
    end else if (!stop && conv_end) begin
      wr_ptr_q <= irq_evt ? 4'h0 : wr_ptr_q + 4'h1;
      if (ch_q == 2'h0 && scan_hit[4]) begin
        scan_pos_q <= scan_hit[3:0] + 4'h1;
      end
      if (irq_evt) begin
        scan_pos_q <= 4'h0;
        half_q     <= half_q ^ split;
      end
      if (seq_end) begin
        seq_cnt_q <= irq_evt ? 4'h0 : seq_cnt_q + 4'h1;
        alt_b_q   <= cr2_q[CR2_ALTERNATE_INPUT_EN] & ~alt_b_q;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (mem_we) begin
      mem[wr_addr] <= res_s2_q;
    end
  end

  assign o_wb_ack        = ack_q;
  assign o_wb_dat        = dat_q;
  assign o_module_on     = on;
  assign o_sh_acquire    = (state_q != ST_SAMPLE) ? 4'h0 :
                           simul ? chan_mask(chps) : (4'h1 << ch_q);
  assign o_conv_active   = (state_q == ST_CONV);
  assign o_conv_ch       = ch_q;
  assign o_use_set_b     = alt_b_q;
  assign o_ch0_input     = alt_b_q ? chs_q[CHS_CH0B +: 4] :
                           (cr2_q[CR2_SCAN] && scan_hit[4]) ? scan_hit[3:0] :
                           chs_q[CHS_CH0A +: 4];
  assign o_ch123_group   = alt_b_q ? chs_q[CHS_GRPB +: 2] : chs_q[CHS_GRPA +: 2];
  assign o_pin_digital   = pcfg_q;
  assign o_conv_irq_flag = flag_q;
  assign o_done          = done_q;

  // second tick count, kept apart from the sequencer's own counter
  logic [3:0] conv_tads_q;
  always_ff @(posedge i_mclk) begin
    if (i_rst || !o_conv_active || conv_end) begin
      conv_tads_q <= 4'h0;
    end else if (tad) begin
      conv_tads_q <= conv_tads_q + 4'h1;
    end
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  a_abort_no_write: assert property (stop |-> !mem_we)
    else $error("result written while module off");
  a_off_wins: assert property (stop |=> state_q == ST_IDLE && !sample_active_q)
    else $error("sequencer still active after turn-off");
  a_batch_done: assert property (irq_evt |=> done_q && flag_q && wr_ptr_q == 4'h0)
    else $error("done or flag missing after batch");
  a_seq_onehot: assert property (state_q == ST_SAMPLE && !simul |-> $onehot(o_sh_acquire))
    else $error("sequential sampling acquires several channels");
  a_simul_group: assert property (state_q == ST_SAMPLE && simul
                                  |-> o_sh_acquire == chan_mask(chps))
    else $error("simultaneous group incomplete");
  a_auto_start: assert property (state_q == ST_SAMPLE && auto_go && !stop
                                 |=> state_q == ST_CONV && conv_cnt_q == 4'h0)
    else $error("auto start missed");
  a_split_swap: assert property (irq_evt && split |=> half_q != $past(half_q))
    else $error("split halves not swapped");
  a_conv_twelve: assert property (conv_end |-> conv_tads_q == CONV_LAST)
    else $error("conversion did not take twelve converter clocks");
  a_alt_off: assert property (!cr2_q[CR2_ALTERNATE_INPUT_EN] && seq_end && !stop |=> !o_use_set_b)
    else $error("set b used with alternation off");
  c_simul_group: cover property (state_q == ST_SAMPLE && simul ##[1:200] seq_end);
  c_split_batch: cover property (irq_evt && split);
  c_abort: cover property (state_q == ST_CONV && stop);
endmodule
`default_nettype wire

// ### rtl/sar_adc_pkg.sv
// constants, register map and state type for the converter sequencer
// assumes a 32-bit classic Wishbone slave with one word per register
package sar_adc_pkg;
  // word indices; byte address is four times the index
  localparam logic [5:0] IDX_CR1  = 6'h00;
  localparam logic [5:0] IDX_CR2  = 6'h01;
  localparam logic [5:0] IDX_CR3  = 6'h02;
  localparam logic [5:0] IDX_CHS  = 6'h03;
  localparam logic [5:0] IDX_PCFG = 6'h04;
  localparam logic [5:0] IDX_SCAN = 6'h05;
  localparam logic [1:0] IDX_RES_HI = 2'h1;
  localparam logic [15:0] RST16 = 16'h0000;
  // control_reg_one
  localparam int CR1_ON = 15;
  localparam int CR1_FORM = 8;
  localparam int CR1_SSRC = 5;
  localparam int CR1_FLAG = 4;
  localparam int CR1_SIMULTANEOUS_SAMPLE_EN = 3;
  localparam int CR1_AUTO_SAMPLE_EN = 2;
  localparam int CR1_SAMPLE_ACTIVE = 1;
  localparam int CR1_DONE = 0;
  localparam logic [15:0] CR1_RW = 16'h83ec;
  // control_reg_two
  localparam int CR2_SCAN = 10;
  localparam int CR2_CHPS = 8;
  localparam int CR2_HALF = 7;
  localparam int CR2_SMPI = 2;
  localparam int CR2_BUFFER_SPLIT_EN = 1;
  localparam int CR2_ALTERNATE_INPUT_EN = 0;
  localparam logic [15:0] CR2_RW = 16'h073f;
  // control_reg_three
  localparam int CR3_AUTO_SAMPLE_CLOCKS = 8;
  localparam int CR3_RC_CLOCK_SELECT = 7;
  localparam int CR3_ADCS = 0;
  localparam logic [15:0] CR3_RW = 16'h1fbf;
  // input_select_reg
  localparam int CHS_CH0A = 0;
  localparam int CHS_GRPA = 4;
  localparam int CHS_CH0B = 8;
  localparam int CHS_GRPB = 12;
  // trigger_source_sel codes
  localparam logic [2:0] SSRC_SW   = 3'h0;
  localparam logic [2:0] SSRC_EXT1 = 3'h1;
  localparam logic [2:0] SSRC_EXT3 = 3'h3;
  localparam logic [2:0] SSRC_AUTO = 3'h7;
  // result formats
  localparam logic [1:0] FORM_INT  = 2'h0;
  localparam logic [1:0] FORM_SINT = 2'h1;
  localparam logic [1:0] FORM_FRAC = 2'h2;
  localparam int RES_W = 10;
  localparam int RES_DEPTH = 16;
  localparam logic [3:0] CONV_LAST = 4'hb;
  localparam logic [4:0] AUTO_SAMPLE_CLOCKS_MIN = 5'h01;
  typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_SYNC, ST_CONV} seq_state_t;
endpackage

// ### rtl/conv_clock_gen.sv
// converter clock tick generator: divided master clock or rc oscillator
// assumes i_mclk runs at twice the instruction rate; rc pin is asynchronous
`timescale 1ns/100ps
`default_nettype none
module conv_clock_gen #(
  parameter int DIV_W = 6
) (
  input  wire logic             i_mclk,
  input  wire logic             i_rst,
  input  wire logic             i_run,
  input  wire logic [DIV_W-1:0] i_div,
  input  wire logic             i_rc_sel,
  input  wire logic             i_rc_clk,
  output logic                  o_tad
);
  logic [DIV_W-1:0] cnt_q;
  logic             rc_s1_q;
  logic             rc_s2_q;
  logic             rc_s3_q;

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      rc_s1_q <= 1'b0;
      rc_s2_q <= 1'b0;
      rc_s3_q <= 1'b0;
    end else begin
      rc_s1_q <= i_rc_clk;
      rc_s2_q <= rc_s1_q;
      rc_s3_q <= rc_s2_q;
    end
  end

  // period is (div+1) master clocks, i.e. instr period times (div+1)/2
  always_ff @(posedge i_mclk) begin
    if (i_rst || !i_run || i_rc_sel) begin
      cnt_q <= '0;
    end else if (cnt_q == i_div) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst || !i_run) begin
      o_tad <= 1'b0;
    end else if (i_rc_sel) begin
      o_tad <= rc_s2_q & ~rc_s3_q;
    end else begin
      o_tad <= (cnt_q == i_div);
    end
  end
endmodule
`default_nettype wire

// ### test/adc_analog_model.sv
// analog side stand-in: mux, hold and converter return a code of the route
// assumes routing outputs stay put for the whole of a conversion
`timescale 1ns/100ps
`default_nettype none
module adc_analog_model (
  input  wire logic       i_mclk,
  input  wire logic       i_conv_active,
  input  wire logic [1:0] i_conv_ch,
  input  wire logic [3:0] i_ch0_input,
  input  wire logic [1:0] i_grp,
  input  wire logic       i_set_b,
  input  wire logic [9:0] i_salt,
  output logic      [9:0] o_result
);
  logic [9:0] code;
  assign code = {1'b1, i_set_b, i_conv_ch,
                 (i_conv_ch == 2'h0) ? {2'h0, i_ch0_input} : {4'h0, i_grp}} ^ i_salt;
  // outside a conversion show the inverse, so an early capture shows up
  always @(posedge i_mclk) begin
    o_result <= i_conv_active ? code : ~code;
  end
endmodule
`default_nettype wire

// ### test/tb.sv
// self-checking bench: wishbone register access plus analog stand-in
// assumes the sequencer register map and one-cycle ack of the hand-over
`timescale 1ns/100ps
`default_nettype none
module tb;
  import sar_adc_pkg::*;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [3:0]  sel = 4'h0;
  logic        rc_clk = 1'b0;
  logic [2:0]  trig = 3'h0;
  logic [9:0]  salt = 10'h000;
  logic [31:0] rdat, q;
  logic        ack, on, conv, setb, flag, done;
  logic [3:0]  acq, in0;
  logic [1:0]  cch, grp;
  logic [9:0]  res;
  logic [15:0] pdig;
  logic [9:0]  exp_mem [16];
  int          error_cnt = 0;
  int          num_checks = 0;
  int          cycles = 0;
  always #4 mclk = ~mclk;
  // free-running oscillator, ten master cycles a period
  always #40 rc_clk = ~rc_clk;
  sar_adc_sequencer i_dut (
    .i_mclk(mclk), .i_rst(rst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(sel), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_rc_clk(rc_clk), .i_ext_trig(trig), .i_conv_result(res), .o_module_on(on),
    .o_sh_acquire(acq), .o_conv_active(conv), .o_conv_ch(cch), .o_ch0_input(in0),
    .o_ch123_group(grp), .o_use_set_b(setb), .o_pin_digital(pdig),
    .o_conv_irq_flag(flag), .o_done(done));
  adc_analog_model i_model (
    .i_mclk(mclk), .i_conv_active(conv), .i_conv_ch(cch), .i_ch0_input(in0),
    .i_grp(grp), .i_set_b(setb), .i_salt(salt), .o_result(res));
  task automatic tally_and_finish();
    $display("checks=%0d errors=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [9:0] exp_res(input logic [1:0] ch, input logic b,
                                         input logic [3:0] in, input logic [1:0] g);
    return {1'b1, b, ch, (ch == 2'h0) ? {2'h0, in} : {4'h0, g}} ^ salt;
  endfunction
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {16'h0, d};
    sel <= 4'h3;
    do begin
      @(posedge mclk);
      n++;
    end while (ack !== 1'b1);
    chk(32'(n), 32'h2);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  // which: 0 done high, 1 conversion high, 2 conversion low
  task automatic wait_on(input int which, input int lim, output int n);
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while ((which == 0 ? done : which == 1 ? conv : ~conv) !== 1'b1 && n < lim);
    chk(32'(n < lim), 32'h1);
  endtask
  task automatic do_reset();
    @(posedge mclk);
    rst <= 1'b1;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
  endtask
  task automatic trig_test(input logic [2:0] src, input logic rc);
    int t, p;
    do_reset();
    p = rc ? 10 : 2;
    bus(1'b1, 8'h08, rc ? 16'h01bf : 16'h0101);
    bus(1'b1, 8'h04, 16'h0000);
    bus(1'b1, 8'h0c, 16'h0005);
    bus(1'b1, 8'h00, 16'(16'h8002 | (src << 5)));
    repeat (40) @(posedge mclk);
    chk({29'h0, on, acq[0], conv}, 32'h6);
    if (src == SSRC_SW) begin
      bus(1'b1, 8'h00, 16'h8000);
    end else begin
      trig <= 3'h1;
      repeat (4) @(posedge mclk);
      trig <= 3'h0;
    end
    wait_on(1, 300, t);
    wait_on(2, 2000, t);
    chk(32'(t >= 11 * p && t <= 13 * p), 32'h1);
    wait_on(0, 100, t);
    bus(1'b0, 8'h40, 16'h0);
    chk(q, {22'h0, exp_res(2'h0, 1'b0, 4'h5, 2'h0)});
    bus(1'b1, 8'h00, 16'h0000);
  endtask
  task automatic run_batch();
    int n, chps, split, smpi, alternate_input_en, scan, sim, dv, t, mx, r0, r1, k, idx, e;
    logic [15:0] chs, mask;
    logic [3:0]  in;
    logic        pc, b;
    do_reset();
    chps = $urandom % 3;
    n = 1 << chps;
    split = $urandom % 2;
    smpi = $urandom % ((split ? 8 : 16) / n);
    alternate_input_en = $urandom % 2;
    scan = (alternate_input_en == 0) && ($urandom % 2 == 1);
    sim = $urandom % 2;
    dv = $urandom % 4;
    chs = 16'($urandom) & 16'h3f3f;
    mask = 16'($urandom);
    if ($countones(mask) <= smpi) mask = 16'hffff;
    salt <= 10'($urandom);
    bus(1'b1, 8'h08, 16'(256 + dv));
    bus(1'b1, 8'h0c, chs);
    bus(1'b1, 8'h14, mask);
    bus(1'b1, 8'h04, 16'((scan << 10) | (chps << 8) | (smpi << 2) | (split << 1) | alternate_input_en));
    bus(1'b0, 8'h08, 16'h0);
    chk(q, 32'(256 + dv));
    // auto trigger, auto sample, one clock of acquisition
    bus(1'b1, 8'h00, 16'(16'h80e6 | (sim << 3)));
    t = 0;
    mx = 0;
    k = 0;
    r0 = 0;
    r1 = 0;
    pc = 1'b0;
    while (done !== 1'b1 && t < 20000) begin
      @(posedge mclk);
      t++;
      if ($countones(acq) > mx) mx = $countones(acq);
      if (conv === 1'b1 && pc === 1'b0) begin
        k++;
        if (k == 1) r0 = t;
        if (k == 2) r1 = t;
      end
      pc = conv;
    end
    chk({30'h0, done, flag}, 32'h3);
    bus(1'b1, 8'h00, 16'h0000);
    chk(32'(mx), 32'((sim && n > 1) ? n : 1));
    if (n == 1 && smpi > 0) chk(32'(r1 - r0), 32'(13 * (dv + 1)));
    bus(1'b0, 8'h04, 16'h0);
    chk(q & 32'h80, split ? 32'h80 : 32'h0);
    for (int s = 0; s <= smpi; s++) begin
      idx = 0;
      in = chs[3:0];
      if (scan) begin
        for (int j = 0; j < 16; j++) begin
          if (mask[j]) begin
            if (idx == s) in = 4'(j);
            idx++;
          end
        end
      end
      b = (alternate_input_en == 1) && (s % 2 == 1);
      for (int c = 0; c < n; c++) begin
        e = s * n + c;
        exp_mem[e] = exp_res(2'(c), b, b ? chs[11:8] : in, b ? chs[13:12] : chs[5:4]);
        bus(1'b0, 8'(64 + 4 * e), 16'h0);
        chk(q, {22'h0, exp_mem[e]});
      end
    end
    // abort in mid conversion must leave the store untouched
    salt <= ~salt;
    bus(1'b1, 8'h40, 16'h0155);
    bus(1'b1, 8'h00, 16'(16'h80e6 | (sim << 3)));
    wait_on(1, 2000, t);
    repeat (3) @(posedge mclk);
    bus(1'b1, 8'h00, 16'h0000);
    repeat (30) @(posedge mclk);
    chk(32'(conv), 32'h0);
    bus(1'b0, 8'h00, 16'h0);
    chk(q & 32'h2, 32'h0);
    for (int i = 0; i < (smpi + 1) * n; i++) begin
      bus(1'b0, 8'(64 + 4 * i), 16'h0);
      chk(q, {22'h0, exp_mem[i]});
    end
  endtask
  initial begin
    void'($urandom(68326));
    do_reset();
    bus(1'b0, 8'h00, 16'h0);
    chk(q, 32'h0);
    bus(1'b1, 8'h20, 16'hffff);
    bus(1'b0, 8'h20, 16'h0);
    chk(q, 32'h0);
    bus(1'b1, 8'h10, 16'h5a3c);
    @(posedge mclk);
    chk(32'(pdig), 32'h5a3c);
    trig_test(SSRC_SW, 1'b0);
    trig_test(SSRC_EXT1, 1'b0);
    trig_test(SSRC_SW, 1'b1);
    repeat (12) run_batch();
    tally_and_finish();
  end
endmodule
`default_nettype wire
